// ===== design/ibma_pkg.sv
`default_nettype none
package ibma_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [11:0] IBMA_CTRL_OFS = 12'h104;
    localparam logic [11:0] IBMA_STAT_OFS = 12'h110;

    // control register field positions
    localparam int IBMA_CTRL_EN_BIT = 31;
    localparam int IBMA_CTRL_DACHK_BIT = 30;
    localparam int IBMA_CTRL_RST_BIT = 29;
    localparam int IBMA_CTRL_PRIO_LSB = 22;
    localparam int IBMA_CTRL_PORT_LSB = 16;
    localparam int IBMA_CTRL_TAG_LSB = 0;

    // control register reset values and the reserved port code
    localparam logic [1:0] IBMA_PRIO_RST = 2'h1;
    localparam logic [2:0] IBMA_PORT_RST = 3'h6;
    localparam logic [2:0] IBMA_PORT_RSVD = 3'h7;
    localparam logic [15:0] IBMA_TAG_RST = 16'h40fe;

    // status register field positions and reset value
    localparam int IBMA_STAT_GOOD_BIT = 31;
    localparam int IBMA_STAT_TXD_BIT = 30;
    localparam int IBMA_STAT_EXD_BIT = 29;
    localparam int IBMA_STAT_EDA_BIT = 14;
    localparam int IBMA_STAT_EFMT_BIT = 13;
    localparam int IBMA_STAT_ECODE_BIT = 12;
    localparam int IBMA_STAT_ECMD_BIT = 11;
    localparam int IBMA_STAT_ESIZE_BIT = 10;
    localparam int IBMA_STAT_LOC_LSB = 0;
    localparam logic [31:0] IBMA_STAT_RST = 32'h0000_0000;

    // ---------------------------------------------------------------
    // frame layout and limits
    // ---------------------------------------------------------------
    localparam logic [8:0] IBMA_POS_DA_END = 9'd6;
    localparam logic [8:0] IBMA_POS_TAG = 9'd13;
    localparam logic [8:0] IBMA_POS_FMT = 9'd15;
    localparam logic [8:0] IBMA_POS_CODE = 9'd17;
    localparam logic [8:0] IBMA_POS_CMD = 9'd18;
    localparam logic [8:0] IBMA_POS_MAX = 9'h1ff;
    localparam logic [8:0] IBMA_MAX_FRAME_BYTES = 9'd320;
    localparam logic [2:0] IBMA_CMD_LAST_BYTE = 3'd7;
    localparam logic [15:0] IBMA_ACC_FORMAT = 16'h9800;
    localparam logic [15:0] IBMA_ACC_CODE_A = 16'h0001;
    localparam logic [15:0] IBMA_ACC_CODE_B = 16'h0002;
    localparam logic [7:0] IBMA_CMD_END = 8'h00;
    localparam logic [7:0] IBMA_CMD_READ = 8'h01;
    localparam logic [7:0] IBMA_CMD_WRITE = 8'h02;

    // strap: synchroniser depth before the strap level is trusted
    localparam logic [1:0] IBMA_STRAP_SETTLE = 2'd2;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        IBMA_ST_IDLE,
        IBMA_ST_HDR,
        IBMA_ST_SKIP,
        IBMA_ST_EXEC,
        IBMA_ST_RESP,
        IBMA_ST_TXWAIT
    } ibma_state_t;

    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [2:0] port;
        logic [7:0] data;
    } ibma_rx_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [23:0] addr;
        logic [31:0] data;
    } ibma_cmd_t;

    typedef struct packed {
        logic start;
        logic [1:0] queue;
        logic [2:0] port;
    } ibma_resp_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ibma_reg_req_t;

endpackage
`default_nettype wire

// ===== design/ibma_strap_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ibma_strap_sync (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic strap_i,
    output logic take_o,
    output logic level_o
);
    import ibma_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [1:0] cnt;
        logic done;
        logic take;
        logic level;
    } ibma_strap_st_t;

    ibma_strap_st_t r, nxt;

    // ---------------------------------------------------------------
    // two-flop sync, then one capture pulse after reset release
    // ---------------------------------------------------------------
    always_comb begin
        nxt = r;
        nxt.s1 = strap_i;
        nxt.s2 = r.s1;
        nxt.take = 1'b0;
        if (!r.done) begin
            if (r.cnt == IBMA_STRAP_SETTLE) begin
                nxt.take = 1'b1;
                nxt.level = r.s2;
                nxt.done = 1'b1;
            end else begin
                nxt.cnt = r.cnt + 2'd1;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign take_o = r.take;
    assign level_o = r.level;
endmodule
`default_nettype wire

// ===== design/ibma_core.sv
// Function
// - enable bit 31 loads from the port-7 receive-valid strap after reset
// - control bit 30 turns on destination address compare; mismatches discarded
// - writing control bit 29 resets the command engine; bit clears itself
// - responses go to the transmit queue in control bits 23:22, reset 01
// - control bits 18:16 pick the single command port; 111 is reserved
// - command frames carry the type value of control bits 15:0, reset 40fe
// - status bit 31 sets when a valid command frame arrives
// - status bit 30 sets once the response frame has been sent
// - status bit 29 sets only after all commands of a frame finished
// - done and error flags clear on a new frame with matching type value
// - with address check on, bit 14 flags a destination address mismatch
// - access format must be 9800; otherwise status bit 13 sets
// - access code must be 0001 or 0002; otherwise status bit 12 sets
// - status bit 11 sets on an unrecognised command code
// - frames above 320 bytes set status bit 10 and get no response
// - status bits 6:0 locate the unrecognised command while bit 11 is set
// - own address spans six byte registers, first holding bits 47:40
`timescale 1ns/1ps
`default_nettype none
module ibma_core (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic port7_receive_valid_strap_i,
    input wire logic [47:0] switch_mac_addr_i,
    input wire ibma_pkg::ibma_reg_req_t reg_req_i,
    input wire ibma_pkg::ibma_rx_t rx_i,
    input wire logic cmd_ack_i,
    input wire logic resp_sent_i,
    output logic [31:0] reg_rdata_o,
    output logic frame_claim_o,
    output ibma_pkg::ibma_cmd_t cmd_o,
    output ibma_pkg::ibma_resp_t resp_o
);
    import ibma_pkg::*;

    parameter int PEND_W = 6;
    // refuse counter widths the logic cannot serve
    if (PEND_W < 1 || PEND_W > 16) begin : g_pend_w_check
        $error("PEND_W out of range");
    end

    // ---------------------------------------------------------------
    // state record
    // ---------------------------------------------------------------
    typedef struct packed {
        ibma_state_t st;
        logic en;
        logic dachk;
        logic rst;
        logic [1:0] prio;
        logic [2:0] port;
        logic [15:0] tag;
        logic good;
        logic txd;
        logic exd;
        logic e_da;
        logic e_fmt;
        logic e_code;
        logic e_cmd;
        logic e_size;
        logic [6:0] loc;
        logic [8:0] cnt;
        logic [7:0] last;
        logic da_bad;
        logic claimed;
        logic [63:0] cw;
        logic [2:0] cb;
        logic [6:0] cidx;
        logic cmd_stop;
        logic [PEND_W-1:0] pend;
        logic [31:0] rdata;
        logic claim;
        ibma_cmd_t cmd;
        ibma_resp_t resp;
    } ibma_core_st_t;

    ibma_core_st_t r, r_nxt;
    logic strap_take;
    logic strap_level;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] mac_byte(input logic [47:0] mac, input logic [8:0] idx);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 6; i++) begin
            if (idx == 9'(i)) begin
                b = mac[47 - 8 * i -: 8];
            end
        end
        return b;
    endfunction

    function automatic logic is_known_cmd(input logic [7:0] code);
        return (code == IBMA_CMD_READ) || (code == IBMA_CMD_WRITE);
    endfunction

    function automatic logic port_selected(input logic [2:0] sel, input logic [2:0] port);
        return (sel != IBMA_PORT_RSVD) && (sel == port);
    endfunction

    function automatic logic [31:0] ctrl_word(input ibma_core_st_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[IBMA_CTRL_EN_BIT] = s.en;
        w[IBMA_CTRL_DACHK_BIT] = s.dachk;
        w[IBMA_CTRL_RST_BIT] = s.rst;
        w[IBMA_CTRL_PRIO_LSB +: 2] = s.prio;
        w[IBMA_CTRL_PORT_LSB +: 3] = s.port;
        w[IBMA_CTRL_TAG_LSB +: 16] = s.tag;
        return w;
    endfunction

    function automatic logic [31:0] stat_word(input ibma_core_st_t s);
        logic [31:0] w;
        w = IBMA_STAT_RST;
        w[IBMA_STAT_GOOD_BIT] = s.good;
        w[IBMA_STAT_TXD_BIT] = s.txd;
        w[IBMA_STAT_EXD_BIT] = s.exd;
        w[IBMA_STAT_EDA_BIT] = s.e_da;
        w[IBMA_STAT_EFMT_BIT] = s.e_fmt;
        w[IBMA_STAT_ECODE_BIT] = s.e_code;
        w[IBMA_STAT_ECMD_BIT] = s.e_cmd;
        w[IBMA_STAT_ESIZE_BIT] = s.e_size;
        w[IBMA_STAT_LOC_LSB +: 7] = s.loc;
        return w;
    endfunction

    // ---------------------------------------------------------------
    // strap capture
    // ---------------------------------------------------------------
    ibma_strap_sync u_strap (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .strap_i(port7_receive_valid_strap_i),
        .take_o(strap_take),
        .level_o(strap_level)
    );

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        logic [8:0] pos;
        logic [15:0] fld;
        logic [63:0] cw;
        logic take;
        logic issue;
        logic hdr_ok;
        pos = rx_i.sof ? 9'd0 : r.cnt;
        fld = {r.last, rx_i.data};
        cw = {r.cw[55:0], rx_i.data};
        issue = 1'b0;
        r_nxt = r;
        r_nxt.cmd.valid = 1'b0;
        r_nxt.resp.start = 1'b0;
        r_nxt.rst = 1'b0;
        hdr_ok = r.claimed && !r.e_da && !r.e_fmt && !r.e_code;
        // only accepted port; a new frame starts only when enabled
        take = rx_i.valid && port_selected(r.port, rx_i.port) && ((r.st == IBMA_ST_HDR)
            || ((r.st == IBMA_ST_IDLE) && rx_i.sof && r.en));

        // register writes; software bits, the strap load
        if (strap_take) begin
            r_nxt.en = strap_level;
        end
        if (reg_req_i.wr && reg_req_i.addr == IBMA_CTRL_OFS) begin
            r_nxt.en = reg_req_i.wdata[IBMA_CTRL_EN_BIT];
            r_nxt.dachk = reg_req_i.wdata[IBMA_CTRL_DACHK_BIT];
            r_nxt.rst = reg_req_i.wdata[IBMA_CTRL_RST_BIT];
            r_nxt.prio = reg_req_i.wdata[IBMA_CTRL_PRIO_LSB +: 2];
            r_nxt.port = reg_req_i.wdata[IBMA_CTRL_PORT_LSB +: 3];
            r_nxt.tag = reg_req_i.wdata[IBMA_CTRL_TAG_LSB +: 16];
        end

        // frame byte processing
        if (take) begin
            r_nxt.st = IBMA_ST_HDR;
            r_nxt.cnt = (pos == IBMA_POS_MAX) ? pos : pos + 9'd1;
            r_nxt.last = rx_i.data;
            if (rx_i.sof) begin
                r_nxt.da_bad = 1'b0;
                r_nxt.claimed = 1'b0;
                r_nxt.cb = 3'd0;
                r_nxt.cidx = 7'd0;
                r_nxt.cmd_stop = 1'b0;
            end
            // own address compare, byte 0 against bits 47:40
            if (pos < IBMA_POS_DA_END && r.dachk
                && rx_i.data != mac_byte(switch_mac_addr_i, pos)) begin
                r_nxt.da_bad = 1'b1;
            end
            if (pos == IBMA_POS_TAG) begin
                if (fld == r.tag) begin
                    r_nxt.claimed = 1'b1;
                    r_nxt.claim = 1'b1;
                    r_nxt.good = 1'b0;
                    r_nxt.txd = 1'b0;
                    r_nxt.exd = 1'b0;
                    r_nxt.e_fmt = 1'b0;
                    r_nxt.e_code = 1'b0;
                    r_nxt.e_cmd = 1'b0;
                    r_nxt.e_size = 1'b0;
                    r_nxt.loc = 7'd0;
                    r_nxt.e_da = r.da_bad;
                end else begin
                    r_nxt.st = IBMA_ST_SKIP;
                end
            end
            if (pos == IBMA_POS_FMT && r.claimed && fld != IBMA_ACC_FORMAT) begin
                r_nxt.e_fmt = 1'b1;
            end
            if (pos == IBMA_POS_CODE && r.claimed
                && fld != IBMA_ACC_CODE_A && fld != IBMA_ACC_CODE_B) begin
                r_nxt.e_code = 1'b1;
            end
            // command words: code, 24-bit address, 32-bit data
            if (pos >= IBMA_POS_CMD && hdr_ok && !r.cmd_stop) begin
                r_nxt.cw = cw;
                r_nxt.cb = r.cb + 3'd1;
                if (r.cb == IBMA_CMD_LAST_BYTE) begin
                    r_nxt.cidx = r.cidx + 7'd1;
                    if (cw[63:56] == IBMA_CMD_END) begin
                        r_nxt.cmd_stop = 1'b1;
                    end else if (is_known_cmd(cw[63:56])) begin
                        issue = 1'b1;
                        r_nxt.cmd = '{valid: 1'b1, code: cw[63:56], addr: cw[55:32],
                                      data: cw[31:0]};
                    end else begin
                        r_nxt.e_cmd = 1'b1;
                        r_nxt.loc = r.cidx;
                        r_nxt.cmd_stop = 1'b1;
                    end
                end
            end
            if (pos >= IBMA_MAX_FRAME_BYTES && r.claimed) begin
                r_nxt.e_size = 1'b1;
            end
            if (rx_i.eof) begin
                r_nxt.claim = 1'b0;
                if (!r_nxt.claimed || r_nxt.e_da || r_nxt.e_size) begin
                    r_nxt.st = IBMA_ST_IDLE;
                end else begin
                    r_nxt.st = IBMA_ST_EXEC;
                    r_nxt.good = !r_nxt.e_fmt && !r_nxt.e_code;
                end
            end
        end else if (r.st == IBMA_ST_SKIP && rx_i.valid && rx_i.eof
            && port_selected(r.port, rx_i.port)) begin
            r_nxt.st = IBMA_ST_IDLE;
        end

        // outstanding command count
        if (issue && !cmd_ack_i) begin
            r_nxt.pend = r.pend + PEND_W'(1);
        end else if (!issue && cmd_ack_i && r.pend != '0) begin
            r_nxt.pend = r.pend - PEND_W'(1);
        end

        // execution wait, response launch, transmit wait
        case (r.st)
            IBMA_ST_EXEC: begin
                if (r.pend == '0) begin
                    r_nxt.exd = !r.e_fmt && !r.e_code && !r.e_cmd;
                    r_nxt.resp = '{start: 1'b1, queue: r.prio, port: r.port};
                    r_nxt.st = IBMA_ST_RESP;
                end
            end
            IBMA_ST_RESP: begin
                r_nxt.st = IBMA_ST_TXWAIT;
                if (resp_sent_i) begin
                    r_nxt.txd = 1'b1;
                    r_nxt.st = IBMA_ST_IDLE;
                end
            end
            IBMA_ST_TXWAIT: begin
                if (resp_sent_i) begin
                    r_nxt.txd = 1'b1;
                    r_nxt.st = IBMA_ST_IDLE;
                end
            end
            default: begin
            end
        endcase

        // engine reset, one cycle after the write
        if (r.rst) begin
            r_nxt.st = IBMA_ST_IDLE;
            r_nxt.cnt = 9'd0;
            r_nxt.pend = '0;
            r_nxt.claim = 1'b0;
            r_nxt.claimed = 1'b0;
            r_nxt.cmd_stop = 1'b0;
            r_nxt.cmd.valid = 1'b0;
            r_nxt.resp.start = 1'b0;
        end

        // register read data, one cycle latency
        r_nxt.rdata = 32'h0000_0000;
        if (reg_req_i.rd) begin
            if (reg_req_i.addr == IBMA_CTRL_OFS) begin
                r_nxt.rdata = ctrl_word(r);
            end else if (reg_req_i.addr == IBMA_STAT_OFS) begin
                r_nxt.rdata = stat_word(r);
            end
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.st <= IBMA_ST_IDLE;
            r.prio <= IBMA_PRIO_RST;
            r.port <= IBMA_PORT_RST;
            r.tag <= IBMA_TAG_RST;
        end else begin
            r <= r_nxt;
        end
    end

    // outputs straight from the state record
    assign reg_rdata_o = r.rdata;
    assign frame_claim_o = r.claim;
    assign cmd_o = r.cmd;
    assign resp_o = r.resp;
endmodule
`default_nettype wire

// ===== dv/ibma_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ibma_monitor #(
    parameter int PEND_W = 6
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire ibma_pkg::ibma_reg_req_t reg_req_i,
    input wire ibma_pkg::ibma_rx_t rx_i,
    input wire logic cmd_ack_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic frame_claim_o,
    input wire ibma_pkg::ibma_cmd_t cmd_o,
    input wire ibma_pkg::ibma_resp_t resp_o
);
    import ibma_pkg::*;
    // ----
    // control shadow and outstanding commands
    // ----
    logic [31:0] ctrl_r;
    logic [PEND_W:0] pend_r;
    logic ctrl_wr;
    logic ctrl_rd;
    assign ctrl_wr = reg_req_i.wr && reg_req_i.addr == IBMA_CTRL_OFS;
    assign ctrl_rd = reg_req_i.rd && reg_req_i.addr == IBMA_CTRL_OFS;
    // follows control writes, counts commands not yet acknowledged
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= 32'h0046_40fe;
            pend_r <= '0;
        end else begin
            ctrl_r <= ctrl_wr ? reg_req_i.wdata : ctrl_r;
            pend_r <= pend_r + (PEND_W+1)'(cmd_o.valid) - (PEND_W+1)'(cmd_ack_i);
        end
    end
    // ----
    // properties
    // ----
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    AST_SC_RESET: assert property (ctrl_wr && reg_req_i.wdata[29] ##2 ctrl_rd
        |=> !reg_rdata_o[29]) else $error("engine reset bit did not clear");
    AST_STAT_RSVD: assert property (reg_req_i.rd && reg_req_i.addr == IBMA_STAT_OFS
        |=> reg_rdata_o[28:15] == 14'h0 && reg_rdata_o[9:7] == 3'h0)
        else $error("status reserved bits set");
    AST_RESP_ROUTE: assert property (resp_o.start |-> resp_o.queue == ctrl_r[23:22]
        && resp_o.port == ctrl_r[18:16]) else $error("response queue or port wrong");
    AST_RESP_PULSE: assert property (resp_o.start |=> !resp_o.start)
        else $error("response start longer than one cycle");
    AST_EXEC_DONE: assert property (resp_o.start |-> pend_r == '0)
        else $error("response while commands outstanding");
    AST_CLAIM_SEL: assert property ($rose(frame_claim_o) |->
        $past(rx_i.port) == ctrl_r[18:16] && $past(rx_i.data) == ctrl_r[7:0])
        else $error("claim on wrong port or type");
    AST_CLAIM_END: assert property (frame_claim_o && rx_i.valid && rx_i.eof
        |=> !frame_claim_o) else $error("claim held after frame end");
    AST_CMD_GAP: assert property (cmd_o.valid |=> !cmd_o.valid [*7])
        else $error("commands closer than one word");
    COV_RESP: cover property (resp_o.start);
    COV_CLAIM: cover property ($rose(frame_claim_o));
    COV_PEND: cover property (cmd_o.valid && pend_r > 1);
endmodule
`default_nettype wire

// ===== dv/ibma_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ibma_host_model (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] lag_i,
    input wire logic cmd_valid_i,
    input wire logic resp_start_i,
    output logic cmd_ack_o,
    output logic resp_sent_o
);
    int due[$];
    int now;
    int tx;
    // acks each command after a lag, reports the response sent
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            due.delete();
            now = 0;
            tx = -1;
            cmd_ack_o <= 1'b0;
            resp_sent_o <= 1'b0;
        end else begin
            now++;
            cmd_ack_o <= due.size() > 0 && due[0] <= now;
            if (due.size() > 0 && due[0] <= now) void'(due.pop_front());
            if (cmd_valid_i) due.push_back(now + 1 + int'(lag_i));
            resp_sent_o <= tx == now;
            if (resp_start_i) tx = now + 2 + int'(lag_i);
        end
    end
endmodule
`default_nettype wire

// ===== dv/ibma_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ibma_core_tb;
    import ibma_pkg::*;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic strap = 1'b1;
    logic [47:0] mac = 48'h02_10_a1_b2_c3_d4;
    ibma_reg_req_t req = '0;
    ibma_rx_t rx = '0;
    logic ack, sent, claim;
    logic [31:0] rdata, r;
    ibma_cmd_t cmd;
    ibma_resp_t resp;
    logic [3:0] lag = 4'h0;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 13;
    int resp_exp = 0;
    int sent_cnt = 0;
    logic claim_seen = 1'b0;
    logic [31:0] stat_exp = 32'h0;
    logic [31:0] ctrl_v = 32'h8046_40fe;
    logic [63:0] cmd_q[$];
    logic [7:0] fb[$];

    always #2.5 core_clk_i = ~core_clk_i;

    ibma_core i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .port7_receive_valid_strap_i(strap), .switch_mac_addr_i(mac), .reg_req_i(req),
        .rx_i(rx), .cmd_ack_i(ack), .resp_sent_i(sent), .reg_rdata_o(rdata),
        .frame_claim_o(claim), .cmd_o(cmd), .resp_o(resp));
    ibma_host_model i_host (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .lag_i(lag),
        .cmd_valid_i(cmd.valid), .resp_start_i(resp.start), .cmd_ack_o(ack),
        .resp_sent_o(sent));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic reg_acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(negedge core_clk_i);
        req = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(negedge core_clk_i);
        req = '0;
        r = rdata;
    endtask

    task automatic put(input logic [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) fb.push_back(v[8*i+:8]);
    endtask

    // builds one frame, drives it and predicts status and commands
    task automatic frame(input logic [2:0] port, input logic [15:0] tag, input logic [15:0] fmt,
            input logic [15:0] code, input int ncmd, input logic [7:0] bad, input int pad,
            input logic [47:0] da, input int cut);
        logic [63:0] w;
        logic live, eda, esz, efm, eco, ok;
        int n;
        live = ctrl_v[31] && port == ctrl_v[18:16] && port != 3'h7 && tag == ctrl_v[15:0];
        lag = 4'($random(seed));
        fb.delete();
        put({16'h0, da}, 6);
        put(48'h02_0000_0000_01, 6);
        put({tag, fmt, code}, 6);
        for (int c = 0; c < ncmd; c++) begin
            w = {$random(seed), $random(seed)};
            w[63:56] = w[0] ? IBMA_CMD_WRITE : IBMA_CMD_READ;
            put(w, 8);
            if (live) cmd_q.push_back(w);
        end
        put({bad, 56'h0}, bad != 8'h00 ? 8 : 0);
        put(64'h0, 8 + pad);
        put(64'hc0ff_ee11, 4);
        n = cut > 0 ? cut : fb.size();
        claim_seen = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk_i);
            rx = '{valid: 1'b1, sof: i == 0, eof: cut == 0 && i == n - 1, port: port, data: fb[i]};
        end
        @(negedge core_clk_i);
        rx = '0;
        check("claim", claim_seen, live);
        if (live && cut == 0) begin
            eda = ctrl_v[30] && da != mac;
            esz = fb.size() > 320;
            efm = fmt != IBMA_ACC_FORMAT;
            eco = code != IBMA_ACC_CODE_A && code != IBMA_ACC_CODE_B;
            ok = !eda && !esz;
            resp_exp += int'(ok);
            stat_exp = {ok && !efm && !eco, ok, ok && !efm && !eco && bad == 8'h00, 14'h0,
                eda, efm, eco, bad != 8'h00, esz, 3'h0, bad != 8'h00 ? 7'(ncmd) : 7'h0};
        end
        for (int i = 0; i < 200 && sent_cnt != resp_exp; i++) @(negedge core_clk_i);
        check("responses", sent_cnt, resp_exp);
        if (sent_cnt != resp_exp) end_of_test();
        repeat (3) @(negedge core_clk_i);
        reg_acc(1'b0, IBMA_STAT_OFS, 32'h0);
        if (cut == 0) begin
            check("stat_done", r[31:15], stat_exp[31:15]);
            check("stat_err", r[14:10], stat_exp[14:10]);
            check("stat_loc", r[9:0], stat_exp[9:0]);
        end
        check("cmd_left", cmd_q.size(), 0);
    endtask

    // watches commands, responses and claim at settled points
    always @(negedge core_clk_i) begin
        if (sent) sent_cnt++;
        if (claim) claim_seen = 1'b1;
        if (cmd.valid) begin
            check("cmd", 64'(cmd), cmd_q.size() > 0 ? cmd_q.pop_front() : 64'hx);
        end
        if (resp.start) begin
            check("resp", {resp.queue, resp.port}, {ctrl_v[23:22], ctrl_v[18:16]});
        end
    end

    initial begin
        repeat (4) @(negedge core_clk_i);
        resetn_i = 1'b1;
        repeat (6) @(negedge core_clk_i);
        reg_acc(1'b0, IBMA_CTRL_OFS, 32'h0);
        check("ctrl_rst", r, ctrl_v);
        reg_acc(1'b1, IBMA_STAT_OFS, 32'hffff_ffff);
        reg_acc(1'b0, 12'h108, 32'h0);
        check("unmapped", r, 32'h0);
        frame(3'h6, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 2, 8'h00, 0, mac, 0);
        frame(3'h6, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_B, 3, 8'h00, 0, mac, 0);
        frame(3'h6, 16'h40fe, 16'h9801, IBMA_ACC_CODE_A, 0, 8'h00, 0, mac, 0);
        frame(3'h6, 16'h40fe, IBMA_ACC_FORMAT, 16'h0003, 0, 8'h00, 0, mac, 0);
        frame(3'h6, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 1, 8'h07, 0, mac, 0);
        frame(3'h6, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 1, 8'h00, 0, ~mac, 0);
        frame(3'h6, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 0, 8'h00, 290, mac, 0);
        frame(3'h6, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 0, 8'h00, 291, mac, 0);
        frame(3'h6, 16'h1234, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 1, 8'h00, 0, mac, 0);
        frame(3'h2, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 1, 8'h00, 0, mac, 0);
        ctrl_v = 32'hc046_40fe;
        reg_acc(1'b1, IBMA_CTRL_OFS, ctrl_v);
        frame(3'h6, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 0, 8'h00, 0, ~mac, 0);
        frame(3'h6, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 1, 8'h00, 0, mac, 0);
        ctrl_v = 32'hc0c2_40fe;
        reg_acc(1'b1, IBMA_CTRL_OFS, ctrl_v);
        frame(3'h2, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_B, 2, 8'h00, 0, mac, 0);
        ctrl_v = 32'h00c2_40fe;
        reg_acc(1'b1, IBMA_CTRL_OFS, ctrl_v);
        frame(3'h2, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 1, 8'h00, 0, mac, 0);
        ctrl_v = 32'h80c7_40fe;
        reg_acc(1'b1, IBMA_CTRL_OFS, ctrl_v);
        frame(3'h7, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 1, 8'h00, 0, mac, 0);
        ctrl_v = 32'h80c2_40fe;
        reg_acc(1'b1, IBMA_CTRL_OFS, ctrl_v);
        frame(3'h2, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 0, 8'h00, 0, mac, 20);
        reg_acc(1'b1, IBMA_CTRL_OFS, ctrl_v | 32'h2000_0000);
        reg_acc(1'b0, IBMA_CTRL_OFS, 32'h0);
        check("ctrl_sc", r, ctrl_v);
        frame(3'h2, 16'h40fe, IBMA_ACC_FORMAT, IBMA_ACC_CODE_A, 2, 8'h00, 0, mac, 0);
        // second reset with the strap low
        strap = 1'b0;
        resetn_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        resetn_i = 1'b1;
        repeat (6) @(negedge core_clk_i);
        ctrl_v = 32'h0046_40fe;
        reg_acc(1'b0, IBMA_CTRL_OFS, 32'h0);
        check("ctrl_strap0", r, ctrl_v);
        end_of_test();
    end
endmodule

bind ibma_core ibma_monitor #(.PEND_W(PEND_W)) i_mon (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .reg_req_i(reg_req_i), .rx_i(rx_i), .cmd_ack_i(cmd_ack_i),
    .reg_rdata_o(reg_rdata_o), .frame_claim_o(frame_claim_o), .cmd_o(cmd_o), .resp_o(resp_o));
`default_nettype wire
